// file: verilog/transceiver_main_iface_ctrl.sv
// main control and pin interface registers with serial configuration port
`timescale 1ns/100ps
`default_nettype none
module transceiver_main_iface_ctrl
  import xcvr_ctrl_pkg::*;
(
  input wire logic clk_i, // 100 MHz core clock
  input wire logic rst_i, // synchronous reset, active high
  input wire pin_in_t pins_i, // raw pins from outside the clock domain
  input wire core_in_t core_i, // status from on-chip logic
  output logic cfg_dout_o, // serial read data pin
  output logic data_io_o, // data pin output value
  output logic data_io_oe_o, // data pin output enable
  output logic data_clock_pin_o, // data clock pin
  output logic lock_pin_o, // lock status pin
  output logic amp_enable_pin_o, // external amplifier enable pin
  output logic low_noise_enable_pin_o, // external low-noise enable pin
  output logic direction_select_o, // 0 receive, 1 transmit
  output logic bank_select_o, // 0 bank A, 1 bank B
  output power_t power_o, // power-down controls
  output logic crystal_bypass_o, // external clock in use
  output logic soft_reset_o, // defaults forced into interface register
  output logic seq_start_o, // pulse: start power-up sequence
  output logic seq_sleep_o, // pulse: enter power-down, wait for start
  output logic calib_request_o, // pulse: calibrate at end of sequence
  output logic test_module_off_o, // analog test module off
  output logic [2:0] test_select_o, // analog test module select
  output logic [7:0] main_o, // main control register
  output logic [7:0] iface_o // pin interface register
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, a change counts when stages two and three agree
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;
  logic [SYNC_W-1:0] filt_r;
  logic [SYNC_W-1:0] filt_old_r;

  assign pin_raw = pins_i;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
          sync3_r[gi] <= 1'b1;
          filt_r[gi] <= 1'b1;
          filt_old_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            filt_r[gi] <= sync3_r[gi];
          end
          filt_old_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  pin_in_t cur_w;
  pin_in_t old_w;
  assign cur_w = filt_r;
  assign old_w = filt_old_r;

  wire sclk_rise = cur_w.cfg_clk & ~old_w.cfg_clk;
  wire sclk_fall = ~cur_w.cfg_clk & old_w.cfg_clk;
  wire sel_fall = ~cur_w.cfg_sel_n & old_w.cfg_sel_n;
  wire dio_fall = ~cur_w.data_io & old_w.data_io;
  wire selected = ~cur_w.cfg_sel_n;

  //////////////////////////////////////////////////////////////////////////////
  // serial frame: 7 address bits, write flag, 8 data bits, msb first
  frame_t frame_r;
  frame_t frame_nxt;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_r;
  logic [7:0] rd_shift_r;
  logic cfg_dout_r;

  wire [15:0] shift_in = {shift_r[14:0], cur_w.cfg_data};
  wire [4:0] bit_cnt_inc = bit_cnt_r + 5'h01;
  wire hdr_done = (frame_r == FR_HEADER) && sclk_rise && (bit_cnt_inc == HDR_BITS);
  wire byte_done = (frame_r == FR_DATA) && sclk_rise && (bit_cnt_inc == FRAME_BITS);
  wire [6:0] hdr_addr = shift_in[7:1];
  wire hdr_write = shift_in[0];
  wire [6:0] frm_addr = shift_r[14:8];
  wire frm_write = shift_r[7];
  wire [7:0] frm_data = shift_in[7:0];
  wire wr_main = byte_done && frm_write && (frm_addr == MAIN_ADDR);
  wire wr_iface = byte_done && frm_write && (frm_addr == IFACE_ADDR);

  // unmapped addresses read as zero
  wire [7:0] rd_value = (hdr_addr == MAIN_ADDR) ? main_o :
                        (hdr_addr == IFACE_ADDR) ? iface_o : 8'h00;

  always_comb begin
    frame_nxt = frame_r;
    unique case (frame_r)
      FR_IDLE: begin
        if (selected) begin
          frame_nxt = FR_HEADER;
        end
      end
      FR_HEADER: begin
        if (!selected) begin
          frame_nxt = FR_IDLE;
        end else if (hdr_done) begin
          frame_nxt = FR_DATA;
        end
      end
      FR_DATA: begin
        if (!selected || byte_done) begin
          frame_nxt = FR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_r <= FR_IDLE;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
    end else begin
      frame_r <= frame_nxt;
      if (frame_r == FR_IDLE) begin
        bit_cnt_r <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_inc;
        shift_r <= shift_in;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_shift_r <= 8'h00;
      cfg_dout_r <= 1'b0;
    end else if (hdr_done) begin
      rd_shift_r <= hdr_write ? 8'h00 : rd_value;
    end else if ((frame_r == FR_DATA) && sclk_fall) begin
      cfg_dout_r <= rd_shift_r[7];
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] main_r;
  logic [7:0] iface_r;
  logic sleep_old_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_r <= MAIN_RST;
      iface_r <= IFACE_RST;
    end else begin
      if (wr_main) begin
        main_r <= frm_data;
      end
      if (!main_r[SRST_BIT]) begin
        iface_r <= IFACE_RST;
      end else if (wr_iface) begin
        iface_r <= frm_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode of register fields
  wire [1:0] scheme = main_r[SCHEME_HI:SCHEME_LO];
  wire is_tx = main_r[DIR_BIT];
  // sequencing relies on the host holding receive direction
  wire seq_mode = (scheme == SCHEME_SEQ) && !is_tx;
  wire [1:0] cal_policy = main_r[CAL_HI:CAL_LO];
  wire split = iface_r[SPLIT_BIT];
  wire bypass = iface_r[BYPASS_BIT];
  wire test_on = core_i.filter_test_enable | core_i.analog_test_enable;

  wire rx_off_w = (scheme == SCHEME_SPLIT) ? is_tx :
                  (scheme == SCHEME_BOTH) ? 1'b1 : core_i.rx_off_req;
  wire amp_off_w = (scheme == SCHEME_SPLIT) ? !is_tx :
                   (scheme == SCHEME_BOTH) ? 1'b1 : core_i.amp_off_req;
  // in sequencing layout bits 3:1 are policy and sleep, not power-down
  wire synth_off_w = !seq_mode && main_r[SYNTH_BIT];
  wire xtal_off_w = (!seq_mode && main_r[XTAL_BIT]) || bypass;
  wire bias_off_w = !seq_mode && main_r[BIAS_BIT];
  power_t power_nxt;
  assign power_nxt = '{rx_chain_off: rx_off_w, amp_off: amp_off_w,
                       synth_off: synth_off_w, crystal_core_off: xtal_off_w,
                       bias_gen_off: bias_off_w, crystal_buf_off: bias_off_w};

  wire sleep_nxt = seq_mode && main_r[SLEEP_BIT] && !sleep_old_r;
  wire start_src = core_i.chip_select_start_opt ? sel_fall : (split && dio_fall);
  wire start_nxt = (scheme == SCHEME_SEQ) && start_src;

  // data pin arrangement
  wire dio_oe_nxt = !split && !is_tx;
  wire lock_pin_nxt = (split && core_i.sync_mode) ? core_i.rx_data : core_i.pll_lock;
  // clock gating
  wire gate_lock = iface_r[LOCK_GATE_BIT] && (scheme == SCHEME_BOTH) && !core_i.pll_lock;
  wire gate_cs = iface_r[CS_GATE_BIT] && !core_i.carrier_sense;
  wire data_clock_pin_sync = (gate_lock || gate_cs) ? 1'b1 : core_i.data_clock;
  wire data_clock_pin_nxt = core_i.sync_mode ? data_clock_pin_sync : (split ? core_i.rx_data : core_i.data_clock);

  // external amplifier pins
  wire amp_pol = iface_r[AMP_POL_BIT];
  wire lna_pol = iface_r[LNA_POL_BIT];
  wire amp_pin_nxt = iface_r[AMP_CTRL_BIT] ? (core_i.pa_on ? amp_pol : !amp_pol) : amp_pol;
  wire lna_pin_nxt = iface_r[LNA_CTRL_BIT] ? (core_i.lna_on ? lna_pol : !lna_pol) : lna_pol;

  // test module
  wire test_off_nxt = test_on ? iface_r[TEST_OFF_BIT] : 1'b1;
  wire [2:0] test_sel_nxt = test_on ? iface_r[2:0] : TEST_SEL_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // calibration span counter
  logic [7:0] seq_cnt_r;
  wire [7:0] seq_cnt_inc = seq_cnt_r + 8'h01;
  wire [7:0] cal_span = (cal_policy == CAL_MID) ? CAL_SPAN_MID : CAL_SPAN_LONG;
  wire span_hit = (seq_cnt_inc == cal_span);
  wire seq_end = seq_mode && core_i.seq_end;
  wire cal_nxt = seq_end && ((cal_policy == CAL_ALWAYS) ||
                 (((cal_policy == CAL_MID) || (cal_policy == CAL_LONG)) && span_hit));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_cnt_r <= 8'h00;
      sleep_old_r <= 1'b0;
    end else begin
      sleep_old_r <= seq_mode && main_r[SLEEP_BIT];
      if (!seq_mode || cal_policy == CAL_NEVER) begin
        seq_cnt_r <= 8'h00;
      end else if (seq_end) begin
        seq_cnt_r <= span_hit ? 8'h00 : seq_cnt_inc;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_io_o <= 1'b0;
      data_io_oe_o <= 1'b0;
      data_clock_pin_o <= 1'b1;
      lock_pin_o <= 1'b0;
      amp_enable_pin_o <= 1'b0;
      low_noise_enable_pin_o <= 1'b0;
      direction_select_o <= 1'b0;
      bank_select_o <= 1'b0;
      power_o <= '0;
      crystal_bypass_o <= 1'b0;
      soft_reset_o <= 1'b0;
      seq_start_o <= 1'b0;
      seq_sleep_o <= 1'b0;
      calib_request_o <= 1'b0;
      test_module_off_o <= 1'b1;
      test_select_o <= TEST_SEL_IDLE;
    end else begin
      data_io_o <= core_i.rx_data;
      data_io_oe_o <= dio_oe_nxt;
      data_clock_pin_o <= data_clock_pin_nxt;
      lock_pin_o <= lock_pin_nxt;
      amp_enable_pin_o <= amp_pin_nxt;
      low_noise_enable_pin_o <= lna_pin_nxt;
      direction_select_o <= main_r[DIR_BIT];
      bank_select_o <= main_r[BANK_BIT];
      power_o <= power_nxt;
      crystal_bypass_o <= bypass;
      soft_reset_o <= !main_r[SRST_BIT];
      seq_start_o <= start_nxt;
      seq_sleep_o <= sleep_nxt;
      calib_request_o <= cal_nxt;
      test_module_off_o <= test_off_nxt;
      test_select_o <= test_sel_nxt;
    end
  end

  assign cfg_dout_o = cfg_dout_r;
  assign main_o = main_r;
  assign iface_o = iface_r;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_byte_written;
    wr_main;
  endsequence

  sequence s_main_seen;
    ##1 (main_r == $past(frm_data)) ##1 (direction_select_o == main_r[DIR_BIT]);
  endsequence

  a_main_write: assert property (s_byte_written |-> s_main_seen)
    else $error("main write not applied");
  a_direction_out: assert property (##1 direction_select_o == $past(main_r[DIR_BIT]))
    else $error("direction output wrong");
  a_bank_out: assert property (##1 bank_select_o == $past(main_r[BANK_BIT]))
    else $error("bank output wrong");
  a_scheme_both_off: assert property ((scheme == SCHEME_BOTH) [*2] |->
    power_o.rx_chain_off && power_o.amp_off)
    else $error("scheme 01 must turn both off");
  a_scheme_split_off: assert property ((scheme == SCHEME_SPLIT) [*2] |->
    power_o.rx_chain_off == $past(is_tx) && power_o.amp_off == !$past(is_tx))
    else $error("scheme 00 power split wrong");
  a_bias_pair: assert property ((!seq_mode) [*2] |->
    power_o.bias_gen_off == $past(main_r[BIAS_BIT]) &&
    power_o.crystal_buf_off == $past(main_r[BIAS_BIT]))
    else $error("bias power-down not followed");
  a_bypass_xtal: assert property (crystal_bypass_o |-> power_o.crystal_core_off)
    else $error("bypass must stop crystal core");
  a_soft_reset_iface: assert property ($past(!main_r[SRST_BIT]) |-> iface_r == IFACE_RST)
    else $error("soft reset did not restore interface");
  a_split_input: assert property (split [*2] |-> !data_io_oe_o)
    else $error("split data pin must not drive");
  a_sleep_pulse: assert property ($rose(seq_mode && main_r[SLEEP_BIT]) |-> ##1 seq_sleep_o
    ##1 !seq_sleep_o)
    else $error("sleep pulse missing");
  a_start_edge: assert property (start_nxt |-> ##1 seq_start_o)
    else $error("sequence start not issued");
  a_no_start: assert property ((scheme != SCHEME_SEQ) [*2] |-> !seq_start_o)
    else $error("start outside sequencing");
  a_amp_static: assert property ((!iface_r[AMP_CTRL_BIT]) [*2] |->
    amp_enable_pin_o == $past(amp_pol))
    else $error("amp pin not static polarity");
  a_lna_static: assert property ((!iface_r[LNA_CTRL_BIT]) [*2] |->
    low_noise_enable_pin_o == $past(lna_pol))
    else $error("low-noise pin not static polarity");
  a_test_idle: assert property ((!test_on) [*2] |->
    test_module_off_o && test_select_o == TEST_SEL_IDLE)
    else $error("test module not idle");
  a_cal_always: assert property (seq_end && cal_policy == CAL_ALWAYS |-> ##1 calib_request_o)
    else $error("calibration not requested");
  a_cal_never: assert property (cal_policy == CAL_NEVER |-> ##1 !calib_request_o)
    else $error("calibration requested under never");
  a_lock_gate: assert property (core_i.sync_mode && gate_lock |-> ##1 data_clock_pin_o)
    else $error("data clock not held by lock gate");
  a_carrier_gate: assert property (core_i.sync_mode && gate_cs |-> ##1 data_clock_pin_o)
    else $error("data clock not held by carrier gate");

endmodule : transceiver_main_iface_ctrl
`default_nettype wire

// file: inc/xcvr_ctrl_pkg.sv
// constants and carrier types for the transceiver main/interface control block
package xcvr_ctrl_pkg;
  localparam logic [6:0] MAIN_ADDR = 7'h00;
  localparam logic [6:0] IFACE_ADDR = 7'h01;
  localparam logic [7:0] MAIN_RST = 8'h01;
  localparam logic [7:0] IFACE_RST = 8'h00;
  // main register fields
  localparam int DIR_BIT = 7;
  localparam int BANK_BIT = 6;
  localparam int SCHEME_HI = 5;
  localparam int SCHEME_LO = 4;
  localparam int SYNTH_BIT = 3;
  localparam int XTAL_BIT = 2;
  localparam int BIAS_BIT = 1;
  localparam int SRST_BIT = 0;
  localparam int CAL_HI = 3;
  localparam int CAL_LO = 2;
  localparam int SLEEP_BIT = 1;
  // interface register fields
  localparam int BYPASS_BIT = 7;
  localparam int SPLIT_BIT = 6;
  localparam int LOCK_GATE_BIT = 5;
  localparam int CS_GATE_BIT = 4;
  localparam int AMP_CTRL_BIT = 3;
  localparam int LNA_CTRL_BIT = 2;
  localparam int AMP_POL_BIT = 1;
  localparam int LNA_POL_BIT = 0;
  localparam int TEST_OFF_BIT = 3;
  // power-down schemes
  localparam logic [1:0] SCHEME_SPLIT = 2'h0;
  localparam logic [1:0] SCHEME_BOTH = 2'h1;
  localparam logic [1:0] SCHEME_MODULE = 2'h2;
  localparam logic [1:0] SCHEME_SEQ = 2'h3;
  // calibration policies and spans
  localparam logic [1:0] CAL_NEVER = 2'h0;
  localparam logic [1:0] CAL_ALWAYS = 2'h1;
  localparam logic [1:0] CAL_MID = 2'h2;
  localparam logic [1:0] CAL_LONG = 2'h3;
  localparam logic [7:0] CAL_SPAN_MID = 8'h10;
  localparam logic [7:0] CAL_SPAN_LONG = 8'hfa;
  localparam logic [2:0] TEST_SEL_IDLE = 3'h1;
  // serial frame
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int SYNC_W = 4;

  typedef struct packed {
    logic cfg_clk;
    logic cfg_data;
    logic cfg_sel_n;
    logic data_io;
  } pin_in_t;

  typedef struct packed {
    logic rx_data;
    logic sync_mode;
    logic pll_lock;
    logic carrier_sense;
    logic pa_on;
    logic lna_on;
    logic filter_test_enable;
    logic analog_test_enable;
    logic chip_select_start_opt;
    logic data_clock;
    logic seq_end;
    logic rx_off_req;
    logic amp_off_req;
  } core_in_t;

  typedef struct packed {
    logic rx_chain_off;
    logic amp_off;
    logic synth_off;
    logic crystal_core_off;
    logic bias_gen_off;
    logic crystal_buf_off;
  } power_t;

  typedef enum logic [1:0] {FR_IDLE, FR_HEADER, FR_DATA} frame_t;
endpackage : xcvr_ctrl_pkg

// file: testbench/host_serial_model.sv
// host microcontroller model driving the serial configuration pins
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  input wire logic clk_i, // core clock
  input wire logic dout_i, // serial read data from the device
  output logic cfg_clk_o, // serial clock, still outside frames
  output logic cfg_data_o, // serial data
  output logic cfg_sel_n_o // serial select, active low
);
  initial begin
    cfg_clk_o = 1'b1;
    cfg_data_o = 1'b1;
    cfg_sel_n_o = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_clk
  // address, write flag, data byte, msb first; whole frames only
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic [15:0] sh;
    sh = {a, w, wd};
    rd = 8'h00;
    cfg_sel_n_o = 1'b0;
    wait_clk(5);
    for (int i = 15; i >= 0; i--) begin
      cfg_clk_o = 1'b0;
      cfg_data_o = sh[i];
      wait_clk(5);
      cfg_clk_o = 1'b1;
      wait_clk(5);
      if (i < 8) rd = {rd[6:0], dout_i};
    end
    cfg_sel_n_o = 1'b1;
    // released data line must not keep its last value
    cfg_data_o = ~cfg_data_o;
    wait_clk(8);
  endtask : frame
endmodule : host_serial_model
`default_nettype wire

// file: testbench/transceiver_main_iface_ctrl_bench.sv
// self-checking bench for the main and pin interface control registers
`timescale 1ns/100ps
`default_nettype none
module transceiver_main_iface_ctrl_bench import xcvr_ctrl_pkg::*;;
  logic clk, rst, dio_drv, h_clk, h_data, h_sel_n, dout, dio_oe, dio_out;
  logic data_clock_pin_pin, lock_pin, amp_pin, lna_pin, dir, bank, xbyp, srst;
  logic seq_start, seq_sleep, cal_req, tmo;
  logic [2:0] tsel;
  logic [7:0] main_v, iface_v, rd, m, v;
  core_in_t core;
  pin_in_t pins;
  power_t pwr;
  int mismatches = 0, n_compared = 0, n_start = 0, n_sleep = 0, n_cal = 0;
  int ends[4] = '{5, 3, 32, 250};
  int cal_exp[4] = '{0, 3, 2, 1};
  assign pins = {h_clk, h_data, h_sel_n, dio_oe ? dio_out : dio_drv};
  transceiver_main_iface_ctrl uut (
    .clk_i(clk), .rst_i(rst), .pins_i(pins), .core_i(core), .cfg_dout_o(dout),
    .data_io_o(dio_out), .data_io_oe_o(dio_oe), .data_clock_pin_o(data_clock_pin_pin),
    .lock_pin_o(lock_pin), .amp_enable_pin_o(amp_pin), .low_noise_enable_pin_o(lna_pin),
    .direction_select_o(dir), .bank_select_o(bank), .power_o(pwr),
    .crystal_bypass_o(xbyp), .soft_reset_o(srst), .seq_start_o(seq_start),
    .seq_sleep_o(seq_sleep), .calib_request_o(cal_req), .test_module_off_o(tmo),
    .test_select_o(tsel), .main_o(main_v), .iface_o(iface_v));
  host_serial_model u_host (
    .clk_i(clk), .dout_i(dout), .cfg_clk_o(h_clk), .cfg_data_o(h_data),
    .cfg_sel_n_o(h_sel_n));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (seq_start === 1'b1) n_start++;
    if (seq_sleep === 1'b1) n_sleep++;
    if (cal_req === 1'b1) n_cal++;
  end
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame(a, 1'b1, d, rd);
  endtask : wr
  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    u_host.frame(a, 1'b0, 8'h00, rd);
    check(what, 16'(exp), 16'(rd));
  endtask : rd_chk
  task automatic seq_pulse();
    core.seq_end = 1'b1;
    tick(1);
    core.seq_end = 1'b0;
    tick(1);
  endtask : seq_pulse
  task automatic dio_fall();
    dio_drv = 1'b0;
    tick(8);
    dio_drv = 1'b1;
    tick(8);
  endtask : dio_fall
  function automatic power_t exp_pwr(input logic [7:0] mv, input core_in_t c);
    power_t p;
    logic sq;
    sq = (mv[5:4] == SCHEME_SEQ);
    p.synth_off = mv[SYNTH_BIT] & ~sq;
    p.crystal_core_off = mv[XTAL_BIT] & ~sq;
    p.bias_gen_off = mv[BIAS_BIT] & ~sq;
    p.crystal_buf_off = mv[BIAS_BIT] & ~sq;
    case (mv[5:4])
      SCHEME_SPLIT: p[5:4] = {mv[DIR_BIT], ~mv[DIR_BIT]};
      SCHEME_BOTH: p[5:4] = 2'b11;
      default: p[5:4] = {c.rx_off_req, c.amp_off_req};
    endcase
    return p;
  endfunction : exp_pwr
  // oe, lock, data clock, amp, low-noise, test off, test select
  function automatic logic [8:0] exp_pins(input logic [7:0] mv, input logic [7:0] iv,
                                          input core_in_t c);
    logic te, sp, dck;
    te = c.filter_test_enable | c.analog_test_enable;
    sp = iv[SPLIT_BIT];
    if (!c.sync_mode) dck = sp ? c.rx_data : c.data_clock;
    else if ((iv[LOCK_GATE_BIT] && mv[5:4] == SCHEME_BOTH && !c.pll_lock)
             || (iv[CS_GATE_BIT] && !c.carrier_sense)) dck = 1'b1;
    else dck = c.data_clock;
    return {~sp & ~mv[DIR_BIT], (sp & c.sync_mode) ? c.rx_data : c.pll_lock, dck,
            (iv[AMP_CTRL_BIT] & ~c.pa_on) ? ~iv[AMP_POL_BIT] : iv[AMP_POL_BIT],
            (iv[LNA_CTRL_BIT] & ~c.lna_on) ? ~iv[LNA_POL_BIT] : iv[LNA_POL_BIT],
            te ? iv[3:0] : {1'b1, TEST_SEL_IDLE}};
  endfunction : exp_pins
  task automatic pin_chk();
    check("pins", 16'(exp_pins(m, v, core)),
          16'({dio_oe, lock_pin, data_clock_pin_pin, amp_pin, lna_pin, tmo, tsel}));
    if (!v[SPLIT_BIT]) check("dio", 16'(core.rx_data), 16'(dio_out));
  endtask : pin_chk
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core = '0;
    dio_drv = 1'b1;
    rst = 1'b1;
    void'($urandom(32'hc522));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    tick(5);
    check("reset", 16'h0100, {main_v, iface_v});
    check("test_idle", 16'({core.data_clock, 1'b1, TEST_SEL_IDLE}), 16'({data_clock_pin_pin, tmo, tsel}));
    for (int i = 0; i < 8; i++) begin
      core = core_in_t'(13'($urandom));
      core.seq_end = 1'b0;
      core.chip_select_start_opt = 1'b0;
      m = 8'($urandom);
      m[5:4] = i[1:0];
      m[SRST_BIT] = 1'b1;
      if (i[1:0] == 2'd3) m[DIR_BIT] = 1'b0;
      wr(MAIN_ADDR, m);
      check("main", 16'(m), 16'(main_v));
      check("dir_bank", 16'(m[7:6]), 16'({dir, bank}));
      check("power", 16'(exp_pwr(m, core)), 16'(pwr));
      rd_chk("main_rd", MAIN_ADDR, m);
    end
    for (int i = 0; i < 10; i++) begin
      core = core_in_t'(13'($urandom));
      core.seq_end = 1'b0;
      m = i[0] ? 8'h11 : 8'h01;
      v = (i == 0) ? 8'h00 : 8'($urandom);
      wr(MAIN_ADDR, m);
      wr(IFACE_ADDR, v);
      check("iface", 16'(v), 16'(iface_v));
      check("bypass", 16'(v[BYPASS_BIT]), 16'(xbyp));
      pin_chk();
    end
    core = '0;
    core.sync_mode = 1'b1;
    core.carrier_sense = 1'b1;
    m = 8'h11;
    v = 8'h20;
    wr(MAIN_ADDR, m);
    wr(IFACE_ADDR, v);
    pin_chk();
    core.pll_lock = 1'b1;
    tick(3);
    pin_chk();
    v = 8'h10;
    wr(IFACE_ADDR, v);
    core.carrier_sense = 1'b0;
    tick(3);
    pin_chk();
    wr(IFACE_ADDR, 8'ha5);
    wr(MAIN_ADDR, 8'h00);
    check("soft_reset", 16'h0100, {7'h00, srst, iface_v});
    wr(MAIN_ADDR, 8'h01);
    check("reset_done", 16'h0001, {7'h00, srst, main_v});
    wr(IFACE_ADDR, 8'h5a);
    rd_chk("iface_rd", IFACE_ADDR, 8'h5a);
    wr(7'h05, 8'hff);
    rd_chk("unmapped", 7'h05, 8'h00);
    check("regs", 16'h015a, {main_v, iface_v});
    core = '0;
    for (int p = 0; p < 4; p++) begin
      wr(MAIN_ADDR, 8'h31);
      wr(MAIN_ADDR, 8'h31 | 8'(p << 2));
      n_cal = 0;
      repeat (ends[p]) seq_pulse();
      tick(3);
      check("calib", 16'(cal_exp[p]), 16'(n_cal));
    end
    n_sleep = 0;
    wr(MAIN_ADDR, 8'h3f);
    wr(MAIN_ADDR, 8'h3f);
    check("sleep", 16'h0001, 16'(n_sleep));
    n_start = 0;
    dio_fall();
    check("start_dio", 16'h0001, 16'(n_start));
    core.chip_select_start_opt = 1'b1;
    dio_fall();
    wr(MAIN_ADDR, 8'h3d);
    check("start_sel", 16'h0002, 16'(n_start));
    report_and_stop();
  end
endmodule : transceiver_main_iface_ctrl_bench
`default_nettype wire
